// file: pdd_core.sv
/*
  dual-modulus pll divider core: reference divider, main and swallow
  counters, modulus control, double-ended phase detector, lock indicator.
  assumes an external dual-modulus prescaler on prescaler_in and static
  programming pins; both pin clocks are sampled by clk_sys (125 MHz).
*/
`timescale 1ns/1ps
`include "pdd_consts.svh"
module pdd_core (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     reference_crystal_in,
  input  wire logic                     prescaler_in,
  input  wire logic [`PDD_RSEL_W-1:0]   reference_select_code,
  input  wire logic [`PDD_MAIN_W-1:0]   main_divide_value,
  input  wire logic [`PDD_SWAL_W-1:0]   swallow_count_value,
  output logic                          reference_crystal_out,
  output logic                          modulus_control,
  output logic                          divided_reference,
  output logic                          divided_vco,
  output pdd_pkg::pdd_det_t             detector_out,
  output logic                          lock_indicator
);

  logic [`PDD_SYNC_W-1:0]   pin_sync;
  logic [`PDD_SYNC_W-1:0]   pin_rise;
  logic [`PDD_RSEL_W-1:0]   rsel;
  logic [`PDD_MAIN_W-1:0]   main_val;
  logic [`PDD_SWAL_W-1:0]   swal_val;
  logic                     vco_tick;
  logic                     ref_tick;

  // reference ratio from the select code
  function automatic logic [`PDD_RCNT_W-1:0] ref_ratio(input logic [`PDD_RSEL_W-1:0] code);
    logic [`PDD_RCNT_W-1:0] r;
    r = `PDD_RDIV_0;
    unique case (code)
      3'h0: r = `PDD_RDIV_0;
      3'h1: r = `PDD_RDIV_1;
      3'h2: r = `PDD_RDIV_2;
      3'h3: r = `PDD_RDIV_3;
      3'h4: r = `PDD_RDIV_4;
      3'h5: r = `PDD_RDIV_5;
      3'h6: r = `PDD_RDIV_6;
      3'h7: r = `PDD_RDIV_7;
    endcase
    return r;
  endfunction

  pdd_pin_sync #(
    .W   (`PDD_SYNC_W),
    .RST (`PDD_SYNC_RST)
  ) i_pdd_pin_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .pin_raw  ({swallow_count_value, main_divide_value, reference_select_code,
                reference_crystal_in, prescaler_in}),
    .pin_sync (pin_sync),
    .pin_rise (pin_rise)
  );

  // field split of the synchronised pins
  assign vco_tick = pin_rise[`PDD_SYNC_PRE];
  assign ref_tick = pin_rise[`PDD_SYNC_XTAL];
  assign rsel     = pin_sync[`PDD_SYNC_RSEL_LO +: `PDD_RSEL_W];
  assign main_val = pin_sync[`PDD_SYNC_MAIN_LO +: `PDD_MAIN_W];
  assign swal_val = pin_sync[`PDD_SYNC_SWAL_LO +: `PDD_SWAL_W];

  // reference divider
  logic [`PDD_RCNT_W-1:0] ref_cnt_r;
  logic [`PDD_RCNT_W-1:0] ref_last;
  logic                   ref_term;
  assign ref_last = ref_ratio(rsel) - `PDD_RCNT_W'(1);
  // a ratio change mid-count takes effect once the count passes it
  assign ref_term = ref_tick && (ref_cnt_r >= ref_last);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_cnt_r <= 12'h000;
    end else if (ref_term) begin
      ref_cnt_r <= 12'h000;
    end else if (ref_tick) begin
      ref_cnt_r <= ref_cnt_r + 12'h001;
    end
  end

  // main and swallow counters
  pdd_pkg::pdd_mod_state_t  state_r;
  pdd_pkg::pdd_mod_state_t  state_nxt;
  logic [`PDD_MAIN_W-1:0]   main_cnt_r;
  logic [`PDD_SWAL_W-1:0]   swal_cnt_r;
  logic                     main_term;
  logic                     swal_done;

  // the last edge of a cycle is the one seen with the count at one
  assign main_term = vco_tick && (main_cnt_r <= 10'h001);
  assign swal_done = vco_tick && (state_r == pdd_pkg::PDD_SWALLOW) && (swal_cnt_r <= 6'h01);

  always_comb begin
    state_nxt = state_r;
    if (main_term) begin
      state_nxt = (swal_val == 6'h00) ? pdd_pkg::PDD_MAIN : pdd_pkg::PDD_SWALLOW;
    end else if (swal_done) begin
      state_nxt = pdd_pkg::PDD_MAIN;
    end
  end

  // step and reload on prescaler edges
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      main_cnt_r <= 10'h000;
      swal_cnt_r <= 6'h00;
      state_r    <= pdd_pkg::PDD_MAIN;
    end else begin
      state_r <= state_nxt;
      if (main_term) begin
        main_cnt_r <= main_val;
        swal_cnt_r <= swal_val;
      end else if (vco_tick) begin
        main_cnt_r <= main_cnt_r - 10'h001;
        if (swal_cnt_r != 6'h00) begin
          swal_cnt_r <= swal_cnt_r - 6'h01;
        end
      end
    end
  end

  // phase/frequency detector
  logic                   ref_flag_r;
  logic                   vco_flag_r;
  logic                   ref_flag_nxt;
  logic                   vco_flag_nxt;
  logic [`PDD_PW_W-1:0]   pw_cnt_r;
  logic                   both;
  logic                   pw_end;
  assign both   = ref_flag_r && vco_flag_r;
  assign pw_end = both && (pw_cnt_r == `PDD_PW_W'(`PDD_MIN_PULSE_CYC - 1));

  // divided edges arm the flags; set beats the joint clear
  assign ref_flag_nxt = ref_term  || (ref_flag_r && !pw_end);
  assign vco_flag_nxt = main_term || (vco_flag_r && !pw_end);

  // joint pulse held for the minimum width so the combiner sees it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ref_flag_r <= 1'b0;
      vco_flag_r <= 1'b0;
      pw_cnt_r   <= 4'h0;
    end else begin
      ref_flag_r <= ref_flag_nxt;
      vco_flag_r <= vco_flag_nxt;
      pw_cnt_r   <= (both && !pw_end) ? pw_cnt_r + 4'h1 : 4'h0;
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reference_crystal_out <= 1'b0;
      modulus_control       <= 1'b1;
      divided_reference     <= 1'b0;
      divided_vco           <= 1'b0;
      detector_out          <= '{ref_side_n: 1'b1, vco_side_n: 1'b1};
      lock_indicator        <= 1'b1;
    end else begin
      reference_crystal_out <= ~pin_sync[`PDD_SYNC_XTAL];
      modulus_control       <= (state_nxt == pdd_pkg::PDD_MAIN);
      divided_reference     <= ref_term;
      divided_vco           <= main_term;
      detector_out.ref_side_n <= ~ref_flag_nxt;
      detector_out.vco_side_n <= ~vco_flag_nxt;
      // lone flag means out of lock
      lock_indicator        <= ~(ref_flag_nxt ^ vco_flag_nxt);
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // main counter steps down by one
  a_main_count_step: assert property (vco_tick && !main_term |=> main_cnt_r == $past(main_cnt_r) - 10'h001)
    else $error("main counter did not step");
  a_ref_ratio_end: assert property (ref_tick && ref_cnt_r == ref_last |=> divided_reference)
    else $error("reference divider missed its terminal count");
  a_main_reload_val: assert property (main_term |=> main_cnt_r == $past(main_val) && divided_vco)
    else $error("main counter not reloaded");
  // control low after reload with swallow
  a_modctl_low_start: assert property (main_term && swal_val != 6'h00 |=>
    !modulus_control && swal_cnt_r == $past(swal_val))
    else $error("modulus control not low at cycle start");
  a_modctl_high_swal: assert property (swal_done && !main_term |=> modulus_control && swal_cnt_r == 6'h00)
    else $error("modulus control not high after swallow");
  // swallow holds zero in main phase
  a_swal_hold_zero: assert property (state_r == pdd_pkg::PDD_MAIN && !main_term |=> swal_cnt_r == 6'h00)
    else $error("swallow counter left zero before reload");
  a_vco_lead_out: assert property ($rose(vco_flag_r) && !ref_flag_r |->
    !detector_out.vco_side_n && detector_out.ref_side_n)
    else $error("vco lead not shown on vco side");
  a_vco_lag_out: assert property ($rose(ref_flag_r) && !vco_flag_r |->
    !detector_out.ref_side_n && detector_out.vco_side_n)
    else $error("vco lag not shown on reference side");
  a_joint_pulse_wid: assert property ($rose(ref_flag_r) && $rose(vco_flag_r) |->
    (!detector_out.ref_side_n && !detector_out.vco_side_n)[*3])
    else $error("joint detector pulse too short");
  // lock low while one side pulses
  a_lock_low_err: assert property ((ref_flag_r ^ vco_flag_r) |-> !lock_indicator)
    else $error("lock indicator high while out of lock");
  a_pfd_vco_in: assert property (main_term |=> vco_flag_r)
    else $error("divided vco edge lost by detector");

  c_swallow_phase:  cover property (swal_done ##[1:1000] main_term);
  c_vco_leads:      cover property ($rose(vco_flag_r) && !ref_flag_r);
  c_in_phase:       cover property ($rose(ref_flag_r) && $rose(vco_flag_r));
  c_vco_lags:       cover property ($rose(ref_flag_r) && !vco_flag_r);

endmodule // pdd_core

// file: pdd_consts.svh
/*
  constants for the dual-modulus divider core: reference ratios, pin
  synchroniser layout, detector pulse width.
  assumes the including file runs on the 125 MHz system clock.
*/
`ifndef PDD_CONSTS_SVH
`define PDD_CONSTS_SVH

// system clock period
`define PDD_CLK_PERIOD_NS 8

// reference divide ratios, indexed by select code
`define PDD_RDIV_0 12'h008
`define PDD_RDIV_1 12'h040
`define PDD_RDIV_2 12'h080
`define PDD_RDIV_3 12'h100
`define PDD_RDIV_4 12'h200
`define PDD_RDIV_5 12'h400
`define PDD_RDIV_6 12'h488
`define PDD_RDIV_7 12'h800

// programmed-value and reference counter widths
`define PDD_MAIN_W 10
`define PDD_SWAL_W 6
`define PDD_RSEL_W 3
`define PDD_RCNT_W 12

// pin synchroniser: {swallow, main, ref select, crystal, prescaler}
`define PDD_SYNC_W 21
`define PDD_SYNC_PRE 0
`define PDD_SYNC_XTAL 1
`define PDD_SYNC_RSEL_LO 2
`define PDD_SYNC_MAIN_LO 5
`define PDD_SYNC_SWAL_LO 15
// open programming pins read as one
`define PDD_SYNC_RST 21'h1FFFFF

// shortest joint low pulse of the detector
`define PDD_MIN_PULSE_NS 20
`define PDD_MIN_PULSE_CYC ((`PDD_MIN_PULSE_NS + `PDD_CLK_PERIOD_NS - 1) / `PDD_CLK_PERIOD_NS)
`define PDD_PW_W 4

`endif

// file: pdd_pkg.sv
/*
  types shared by the dual-modulus divider core.
  assumes pdd_consts.svh is not needed here; types only.
*/
package pdd_pkg;

  // modulus phase of one divide cycle, gray along swallow -> main
  typedef enum logic [1:0] {
    PDD_SWALLOW = 2'b00,
    PDD_MAIN    = 2'b01
  } pdd_mod_state_t;

  // double-ended detector outputs, both active low
  typedef struct packed {
    logic ref_side_n;
    logic vco_side_n;
  } pdd_det_t;

endpackage

// file: pdd_pin_sync.sv
/*
  two-flop synchroniser for a group of pins, with a rise pulse per bit.
  assumes the pins are asynchronous to clk_sys and slower than half its rate.
*/
`timescale 1ns/1ps
module pdd_pin_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pin_raw,
  output logic      [W-1:0] pin_sync,
  output logic      [W-1:0] pin_rise
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] last_r;

  // first stage is read only by the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_r <= RST;
      sync_r <= RST;
      last_r <= RST;
    end else begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign pin_sync = sync_r;
  assign pin_rise = sync_r & ~last_r;

endmodule // pdd_pin_sync

// file: pdd_prescaler_model.sv
/*
  behavioural dual-modulus prescaler that feeds the divider core.
  assumes one vco period equals one clk_sys period and P is even.
*/
`timescale 1ns/1ps
module pdd_prescaler_model #(
  parameter int P = 8
) (
  clk_sys,
  modulus_control,
  prescaler_out
);
  input  wire logic clk_sys;
  input  wire logic modulus_control;
  output logic      prescaler_out = 1'b0;

  int phase_r = 0;
  int phase_nxt;

  // control sampled at the last phase, well after the core's 3-4 clock latency
  // divide by P high, P+1 low
  assign phase_nxt = (phase_r >= P - 1 + int'(modulus_control === 1'b0)) ? 0 : phase_r + 1;

  // half period high, rest low: every pin level is held well over 2 clocks
  always @(posedge clk_sys) begin
    phase_r       <= phase_nxt;
    prescaler_out <= (phase_nxt < P / 2);
  end
endmodule // pdd_prescaler_model

// file: pdd_core_bench.sv
/*
  self-checking bench for the divider core with a prescaler model.
  assumes the crystal runs at a quarter of clk_sys and the prescaler P is 8.
*/
`timescale 1ns/1ps
module pdd_core_bench;
  localparam int P = 8;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reference_crystal_in = 1'b0;
  logic              prescaler_in;
  logic [2:0]        reference_select_code = 3'h7;
  logic [9:0]        main_divide_value = 10'h3FF;
  logic [5:0]        swallow_count_value = 6'h3F;
  logic              modulus_control;
  logic              divided_reference;
  logic              divided_vco;
  logic              lock_indicator;
  logic              xtal_out;
  pdd_pkg::pdd_det_t detector_out;
  logic [1:0]        xtal_cnt = 2'h0;
  int                n_mismatch = 0;
  int                samples_checked = 0;

  always #4 clk_sys = ~clk_sys;

  // crystal at clk/4, two clocks high, two low
  always @(posedge clk_sys) begin
    xtal_cnt             <= xtal_cnt + 2'h1;
    reference_crystal_in <= xtal_cnt[1];
  end

  pdd_prescaler_model #(.P(P)) i_pdd_prescaler_model (
    .clk_sys        (clk_sys),
    .modulus_control(modulus_control),
    .prescaler_out  (prescaler_in)
  );

  pdd_core i_pdd_core (
    .clk_sys              (clk_sys),
    .sys_rst              (sys_rst),
    .reference_crystal_in (reference_crystal_in),
    .prescaler_in         (prescaler_in),
    .reference_select_code(reference_select_code),
    .main_divide_value    (main_divide_value),
    .swallow_count_value  (swallow_count_value),
    .reference_crystal_out(xtal_out),
    .modulus_control      (modulus_control),
    .divided_reference    (divided_reference),
    .divided_vco          (divided_vco),
    .detector_out         (detector_out),
    .lock_indicator       (lock_indicator)
  );

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("BAD %s expected %0d seen %0d", what, exp, seen);
      n_mismatch++;
    end
  endtask

  // clocks from just after one pulse up to the next, and clocks with control low
  task automatic next_pulse(input bit vco, output int n, output int low);
    n = 0;
    low = 0;
    do begin
      @(negedge clk_sys);
      n++;
      if (modulus_control === 1'b0) low++;
    end while ((vco ? divided_vco : divided_reference) !== 1'b1 && n < 20000);
    if (n >= 20000) begin
      n_mismatch++;
      wrap_up();
    end
  endtask

  task automatic set_pins(input logic [2:0] code, input logic [9:0] n, input logic [5:0] a);
    @(posedge clk_sys);
    reference_select_code <= code;
    main_divide_value     <= n;
    swallow_count_value   <= a;
  endtask

  task automatic t_reset;
    @(negedge clk_sys);
    check("control in reset", modulus_control, 1'b1);
    check("detector in reset", detector_out, 2'h3);
    check("lock in reset", lock_indicator, 1'b1);
    check("vco pulse in reset", divided_vco, 1'b0);
  endtask

  // programmed values kept legal, swallow never above main
  // legal programming table
  task automatic t_modulus;
    logic [9:0] tn[4] = '{10'h003, 10'h005, 10'h005, 10'h203};
    logic [5:0] ta[4] = '{6'h00, 6'h02, 6'h05, 6'h3F};
    int n, low;
    for (int i = 0; i < 4; i++) begin
      set_pins(3'h0, tn[i], ta[i]);
      next_pulse(1'b1, n, low);
      next_pulse(1'b1, n, low);
      for (int k = 0; k < 2; k++) begin
        next_pulse(1'b1, n, low);
        check("divide cycle clocks", n, tn[i] * P + ta[i]);
        check("control low clocks", low, ta[i] * (P + 1));
      end
    end
  endtask

  task automatic t_refdiv;
    int ratio[8] = '{8, 64, 128, 256, 512, 1024, 1160, 2048};
    int n, low;
    for (int c = 0; c < 8; c++) begin
      set_pins(c[2:0], 10'h005, 6'h01);
      next_pulse(1'b0, n, low);
      next_pulse(1'b0, n, low);
      check("reference period", n, ratio[c] * 4);
    end
  endtask

  // reference period 32 clocks; vco period n*8 clocks
  task automatic t_detector(input logic [9:0] n, input bit fast);
    int g, low, ref_only, vco_only, bad_lock, bad_xtal;
    logic [2:0] xh;
    ref_only = 0;
    vco_only = 0;
    bad_lock = 0;
    bad_xtal = 0;
    xh = 3'h0;
    set_pins(3'h0, n, 6'h00);
    repeat (4) next_pulse(1'b1, g, low);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk_sys);
      // buffered crystal is the inverse, three clocks behind the pin
      if (i >= 3 && xtal_out !== ~xh[2]) bad_xtal++;
      xh = {xh[1:0], reference_crystal_in};
      if (detector_out === 2'b01) ref_only++;
      if (detector_out === 2'b10) vco_only++;
      if (lock_indicator !== ~(detector_out.ref_side_n ^ detector_out.vco_side_n)) bad_lock++;
    end
    check("lone lagging side", fast ? ref_only : vco_only, 0);
    check("leading side active", (fast ? vco_only : ref_only) > 0, 1'b1);
    check("lock mismatches", bad_lock, 0);
    check("crystal out inverse", bad_xtal, 0);
  endtask

  initial begin
    repeat (9) @(posedge clk_sys);
    t_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_modulus();
    t_refdiv();
    t_detector(10'h003, 1'b1);
    t_detector(10'h005, 1'b0);
    wrap_up();
  end
endmodule // pdd_core_bench
